// ---- tseg_avmm_slave.sv ----
// module: avalon-mm slave front end with one wait cycle per access
`timescale 1ns/1ps
`default_nettype none
module tseg_avmm_slave (
    input  wire logic        clk_i,         // system clock
    input  wire logic        rst_b_i,       // sync reset, active low
    input  wire logic        read_i,        // avalon read
    input  wire logic        write_i,       // avalon write
    input  wire logic [31:0] rdata_i,       // read mux from register file
    output logic             waitrequest_o, // avalon waitrequest
    output logic [31:0]      readdata_o,    // avalon readdata
    output logic             wr_stb_o,      // write takes effect this cycle
    output logic             rd_stb_o       // read completes this cycle
);
    logic wait_ff; // high except in the answer cycle

    // first request cycle waits, the next one answers
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= !((read_i || write_i) && wait_ff);
        end
    end

    // read data captured in the waiting cycle, stands in the answer cycle
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            readdata_o <= 32'h0000_0000;
        end else if (read_i && wait_ff) begin
            readdata_o <= rdata_i;
        end
    end

    assign waitrequest_o = wait_ff;
    assign wr_stb_o      = write_i && !wait_ff;
    assign rd_stb_o      = read_i && !wait_ff;
endmodule : tseg_avmm_slave
`default_nettype wire

// ---- tseg_counter.sv ----
// module: 16-bit counter with prescaler, up, down and center-aligned
`timescale 1ns/1ps
`default_nettype none
module tseg_counter (
    input  wire logic        clk_i,    // system clock
    input  wire logic        rst_b_i,  // sync reset, active low
    input  wire logic        run_i,    // counting enabled
    input  wire logic        down_i,   // down counting
    input  wire logic        center_i, // center-aligned counting
    input  wire logic [15:0] presc_i,  // prescaler divide minus one
    input  wire logic [15:0] reload_i, // auto-reload value
    input  wire logic        force_i,  // software update event
    output logic [15:0]      count_o,  // counter value
    output logic             tick_o,   // counter advances this cycle
    output logic             wrap_o    // overflow or underflow this cycle
);
    logic [15:0] psc_ff;  // prescaler counter
    logic [15:0] cnt_ff;  // main counter
    logic        fall_ff; // center-aligned phase, counting down

    assign tick_o  = run_i && (psc_ff == presc_i);
    assign count_o = cnt_ff;
    assign wrap_o  = tick_o && (center_i ? ((!fall_ff && cnt_ff >= reload_i)
                                          || (fall_ff && cnt_ff == tseg_pkg::RST_16))
                              : (down_i ? (cnt_ff == tseg_pkg::RST_16)
                                        : (cnt_ff >= reload_i)));

    // prescaler: cleared together with the counter on a forced update
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            psc_ff <= tseg_pkg::RST_16;
        end else if (force_i) begin
            psc_ff <= tseg_pkg::RST_16;
        end else if (run_i) begin
            psc_ff <= tick_o ? tseg_pkg::RST_16 : psc_ff + 16'h0001;
        end
    end

    // counter: forced update reinitialises, else counts on each tick
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cnt_ff  <= tseg_pkg::RST_16;
            fall_ff <= 1'b0;
        end else if (force_i) begin
            // down counting reloads, up or center clears
            cnt_ff  <= (down_i && !center_i) ? reload_i : tseg_pkg::RST_16;
            fall_ff <= 1'b0;
        end else if (tick_o) begin
            if (center_i) begin
                if (!fall_ff) begin // rising half
                    if (cnt_ff >= reload_i) begin
                        cnt_ff  <= cnt_ff - 16'h0001;
                        fall_ff <= 1'b1;
                    end else begin
                        cnt_ff <= cnt_ff + 16'h0001;
                    end
                end else if (cnt_ff == tseg_pkg::RST_16) begin // bottom
                    cnt_ff  <= 16'h0001;
                    fall_ff <= 1'b0;
                end else begin
                    cnt_ff <= cnt_ff - 16'h0001;
                end
            end else if (down_i) begin
                cnt_ff <= (cnt_ff == tseg_pkg::RST_16) ? reload_i : cnt_ff - 16'h0001;
            end else begin
                cnt_ff <= (cnt_ff >= reload_i) ? tseg_pkg::RST_16 : cnt_ff + 16'h0001;
            end
        end
    end
endmodule : tseg_counter
`default_nettype wire

// ---- tseg_event_gen.sv ----
// module: timer with software event generation, flags and register file
//
// Contract
// - trigger command sets trigger flag, may interrupt
// - trigger command bit clears itself
// - chan1 command sets chan1 flag, may interrupt
// - chan1 command bit clears itself
// - forced chan1 event in input mode captures counter
// - forced capture over set flag sets overcapture
// - channels 2 to 4 behave like channel 1
// - update clears counter, or reloads when down
// - update clears prescaler; update bit clears itself
// - mode register holds channel 2 compare fields
// - update flag set on every update, cleared by zero
`timescale 1ns/1ps
`default_nettype none
module tseg_event_gen (
    input  wire logic        clk_i,          // system clock, 50 MHz
    input  wire logic        rst_b_i,        // sync reset, active low
    input  wire logic [7:0]  address_i,      // avalon byte address
    input  wire logic        read_i,         // avalon read
    input  wire logic        write_i,        // avalon write
    input  wire logic [31:0] writedata_i,    // avalon write data
    input  wire logic [3:0]  byteenable_i,   // avalon byte enables
    output logic [31:0]      readdata_o,     // avalon read data
    output logic             waitrequest_o,  // avalon waitrequest
    output logic             irq_o           // level interrupt
);
    localparam int NC = tseg_pkg::NUM_CHAN; // channel count

    // merge write data into a register under the byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // a channel is an input when its selection field is nonzero
    function automatic logic chan_is_input(input logic [1:0] sel);
        return sel != 2'h0;
    endfunction : chan_is_input

    // bus front end signals
    logic        wr_stb;   // write accepted this cycle
    logic        rd_stb;   // read accepted this cycle
    logic [31:0] rd_mux;   // read data selected by address
    logic [31:0] wd_be;    // write data gated by byte enables

    // software-visible state
    logic [tseg_pkg::CTRL_W-1:0] ctrl_ff;      // counter control
    logic [15:0]                 presc_ff;     // prescaler value
    logic [15:0]                 reload_ff;    // auto-reload value
    logic [tseg_pkg::CM_W-1:0]   cmode_a_ff;   // channel_mode_a
    logic [tseg_pkg::CM_W-1:0]   cmode_b_ff;   // channel 3/4 mode
    logic [15:0]                 ccr_ff [NC];  // capture/compare values
    logic [tseg_pkg::FL_W-1:0]   flags_ff;     // timer_flags
    logic [tseg_pkg::FL_W-1:0]   nxt_flags;    // next timer_flags
    logic [tseg_pkg::EV_W-1:0]   evgen_ff;     // command bits, one cycle
    logic [tseg_pkg::EV_W-1:0]   irq_stat_ff;  // sticky interrupt status
    logic [tseg_pkg::EV_W-1:0]   irq_mask_ff;  // interrupt mask
    logic                        irq_ff;       // interrupt output register

    // counter outputs and derived events
    logic [15:0]                 count;        // counter value
    logic                        tick;         // counter advances
    logic                        wrap;         // over/underflow
    logic                        upd_evt;      // any update event
    logic [NC-1:0]               chan_in;      // channel in input mode
    logic [NC-1:0]               chan_evt;     // channel event this cycle
    logic [NC-1:0]               chan_cap;     // capture this cycle
    logic [tseg_pkg::EV_W-1:0]   ev_now;       // events in status layout

    // avalon slave with one wait cycle
    tseg_avmm_slave u_slave (
        .clk_i         (clk_i),
        .rst_b_i       (rst_b_i),
        .read_i        (read_i),
        .write_i       (write_i),
        .rdata_i       (rd_mux),
        .waitrequest_o (waitrequest_o),
        .readdata_o    (readdata_o),
        .wr_stb_o      (wr_stb),
        .rd_stb_o      (rd_stb)
    );

    // counter and prescaler
    tseg_counter u_counter (
        .clk_i    (clk_i),
        .rst_b_i  (rst_b_i),
        .run_i    (ctrl_ff[tseg_pkg::CTRL_RUN]),
        .down_i   (ctrl_ff[tseg_pkg::CTRL_DOWN]),
        .center_i (|ctrl_ff[tseg_pkg::CTRL_CMS_H:tseg_pkg::CTRL_CMS_L]),
        .presc_i  (presc_ff),
        .reload_i (reload_ff),
        .force_i  (evgen_ff[tseg_pkg::EV_UPDATE]),
        .count_o  (count),
        .tick_o   (tick),
        .wrap_o   (wrap)
    );

    assign wd_be = be_merge(32'h0000_0000, writedata_i, byteenable_i);

    // channel modes: first two in channel_mode_a, rest in the second one
    assign chan_in[0] = chan_is_input(cmode_a_ff[tseg_pkg::CM_SEL_LO +: 2]);
    assign chan_in[1] = chan_is_input(cmode_a_ff[tseg_pkg::CM_SEL_HI +: 2]);
    assign chan_in[2] = chan_is_input(cmode_b_ff[tseg_pkg::CM_SEL_LO +: 2]);
    assign chan_in[3] = chan_is_input(cmode_b_ff[tseg_pkg::CM_SEL_HI +: 2]);

    // update event from overflow or underflow or from the command bit
    assign upd_evt = wrap || evgen_ff[tseg_pkg::EV_UPDATE];

    // channel events: software command, or compare match in output mode
    always_comb begin
        for (int c = 0; c < NC; c++) begin
            chan_evt[c] = evgen_ff[tseg_pkg::EV_CHAN1 + c]
                        || (!chan_in[c] && tick && count == ccr_ff[c]);
            chan_cap[c] = evgen_ff[tseg_pkg::EV_CHAN1 + c] && chan_in[c];
        end
    end

    // events gathered in the status layout
    always_comb begin
        ev_now                         = '0;
        ev_now[tseg_pkg::EV_UPDATE]    = upd_evt;
        ev_now[tseg_pkg::EV_CHAN1 +: NC] = chan_evt;
        ev_now[tseg_pkg::EV_TRIGGER]   = evgen_ff[tseg_pkg::EV_TRIGGER];
    end

    // command register: written ones live one cycle, zeros do nothing
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            evgen_ff <= '0;
        end else if (wr_stb && address_i == tseg_pkg::OFF_EVGEN) begin
            evgen_ff <= wd_be[tseg_pkg::EV_W-1:0] & tseg_pkg::EV_MASK;
        end else begin
            evgen_ff <= '0;
        end
    end

    // control and value registers
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl_ff   <= '0;
            presc_ff  <= tseg_pkg::RST_16;
            reload_ff <= tseg_pkg::RST_16;
        end else if (wr_stb) begin
            case (address_i)
                tseg_pkg::OFF_CTRL: begin // run, direction, center mode
                    ctrl_ff <= tseg_pkg::CTRL_W'(be_merge({28'h0000000, ctrl_ff}, writedata_i,
                                        byteenable_i));
                end
                tseg_pkg::OFF_PRESC: begin // prescaler divide
                    presc_ff <= 16'(be_merge({16'h0000, presc_ff}, writedata_i,
                                         byteenable_i));
                end
                tseg_pkg::OFF_RELOAD: begin // auto-reload
                    reload_ff <= 16'(be_merge({16'h0000, reload_ff}, writedata_i,
                                          byteenable_i));
                end
                default: begin // other addresses leave these alone
                end
            endcase
        end
    end

    // channel mode registers, compare fields of the second channel included
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cmode_a_ff <= tseg_pkg::RST_16;
            cmode_b_ff <= tseg_pkg::RST_16;
        end else if (wr_stb && address_i == tseg_pkg::OFF_CMODE_A) begin
            // bits 15, 14:12 and 11 hold clear enable, mode, preload
            cmode_a_ff <= tseg_pkg::CM_W'(be_merge({16'h0000, cmode_a_ff}, writedata_i,
                                   byteenable_i));
        end else if (wr_stb && address_i == tseg_pkg::OFF_CMODE_B) begin
            cmode_b_ff <= tseg_pkg::CM_W'(be_merge({16'h0000, cmode_b_ff}, writedata_i,
                                   byteenable_i));
        end
    end

    // capture/compare values: a forced capture beats a software write
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            for (int c = 0; c < NC; c++) begin
                ccr_ff[c] <= tseg_pkg::RST_16;
            end
        end else begin
            for (int c = 0; c < NC; c++) begin
                if (chan_cap[c]) begin // input mode: take the counter
                    ccr_ff[c] <= count;
                end else if (wr_stb && address_i == tseg_pkg::OFF_CCR1 + 8'(c * 4)) begin
                    ccr_ff[c] <= 16'(be_merge({16'h0000, ccr_ff[c]}, writedata_i,
                                          byteenable_i));
                end
            end
        end
    end

    // flags: writing zero clears, hardware set wins over the clear
    always_comb begin
        nxt_flags = flags_ff;
        if (wr_stb && address_i == tseg_pkg::OFF_FLAGS) begin
            nxt_flags = flags_ff & (writedata_i[tseg_pkg::FL_W-1:0]
                                    | ~tseg_pkg::FL_W'(be_merge(32'h0000_0000, 32'hffff_ffff,
                                                byteenable_i)));
        end
        // set by events, same layout for the low bits
        nxt_flags[tseg_pkg::EV_W-1:0] = nxt_flags[tseg_pkg::EV_W-1:0] | ev_now;
        for (int c = 0; c < NC; c++) begin
            // capture while the channel flag is already up
            if (chan_cap[c] && flags_ff[tseg_pkg::EV_CHAN1 + c]) begin
                nxt_flags[tseg_pkg::FL_OVCAP1 + c] = 1'b1;
            end
        end
        nxt_flags = nxt_flags & tseg_pkg::FL_MASK;
    end

    // flag register
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // sticky interrupt status: read clears what was returned, events win
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_stat_ff <= '0;
        end else if (rd_stb && address_i == tseg_pkg::OFF_IRQ_STAT) begin
            irq_stat_ff <= (irq_stat_ff & ~readdata_o[tseg_pkg::EV_W-1:0]) | ev_now;
        end else begin
            irq_stat_ff <= irq_stat_ff | ev_now;
        end
    end

    // interrupt mask, same layout; a one blocks
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_mask_ff <= '0;
        end else if (wr_stb && address_i == tseg_pkg::OFF_IRQ_MASK) begin
            irq_mask_ff <= tseg_pkg::EV_W'(be_merge({25'h0000000, irq_mask_ff}, writedata_i,
                                    byteenable_i))
                           & tseg_pkg::EV_MASK;
        end
    end

    // level interrupt while an unmasked status bit is set
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_stat_ff & ~irq_mask_ff);
        end
    end
    assign irq_o = irq_ff;

    // read mux; command register and unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (address_i)
            tseg_pkg::OFF_CTRL:     rd_mux[tseg_pkg::CTRL_W-1:0] = ctrl_ff;
            tseg_pkg::OFF_FLAGS:    rd_mux[tseg_pkg::FL_W-1:0]   = flags_ff;
            tseg_pkg::OFF_CMODE_A:  rd_mux[tseg_pkg::CM_W-1:0]   = cmode_a_ff;
            tseg_pkg::OFF_CMODE_B:  rd_mux[tseg_pkg::CM_W-1:0]   = cmode_b_ff;
            tseg_pkg::OFF_COUNT:    rd_mux[15:0]                 = count;
            tseg_pkg::OFF_PRESC:    rd_mux[15:0]                 = presc_ff;
            tseg_pkg::OFF_RELOAD:   rd_mux[15:0]                 = reload_ff;
            tseg_pkg::OFF_IRQ_STAT: rd_mux[tseg_pkg::EV_W-1:0]   = irq_stat_ff;
            tseg_pkg::OFF_IRQ_MASK: rd_mux[tseg_pkg::EV_W-1:0]   = irq_mask_ff;
            default: begin
                for (int c = 0; c < NC; c++) begin
                    if (address_i == tseg_pkg::OFF_CCR1 + 8'(c * 4)) begin
                        rd_mux[15:0] = ccr_ff[c];
                    end
                end
            end
        endcase
    end
endmodule : tseg_event_gen
`default_nettype wire

// ---- tseg_event_gen_chk.sv ----
// checker: bus handshake, self-clearing commands and event interrupts
`timescale 1ns/1ps
`default_nettype none
module tseg_event_gen_chk (
    input wire logic        clk_i,         // system clock
    input wire logic        rst_b_i,       // sync reset, active low
    input wire logic [7:0]  address_i,     // byte address
    input wire logic        read_i,        // bus read
    input wire logic        write_i,       // bus write
    input wire logic [31:0] writedata_i,   // write data
    input wire logic [3:0]  byteenable_i,  // byte enables
    input wire logic [31:0] readdata_o,    // read data
    input wire logic        waitrequest_o, // wait
    input wire logic        irq_o          // level interrupt
);
    logic [6:0] mask_ff; // copy of the irq mask taken on the bus
    // follow mask writes so irq checks know which events may interrupt
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mask_ff <= 7'h00;
        end else if (write_i && !waitrequest_o && address_i == tseg_pkg::OFF_IRQ_MASK
                     && byteenable_i[0]) begin
            mask_ff <= writedata_i[6:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // read of a given place, taken this cycle
    sequence s_rd_take(a);
        read_i && !waitrequest_o && address_i == a;
    endsequence
    // unmasked command bit taken this cycle
    sequence s_cmd_take(b);
        write_i && !waitrequest_o && address_i == tseg_pkg::OFF_EVGEN && writedata_i[b]
            && !mask_ff[b];
    endsequence
    a_ack_one_wait: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
        else $error("request not answered after one wait cycle");
    a_ack_one_cycle: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_ack_needs_req: assert property ($fell(waitrequest_o) |-> $past(read_i || write_i))
        else $error("answer without a request");
    a_rdata_holds: assert property ($changed(readdata_o) |-> $past(read_i && waitrequest_o))
        else $error("read data changed outside a read");
    a_cmd_reads_zero: assert property (s_rd_take(tseg_pkg::OFF_EVGEN) |-> readdata_o == 32'h0)
        else $error("command bits did not clear themselves");
    a_mode_upper_zero: assert property (s_rd_take(tseg_pkg::OFF_CMODE_A) |-> readdata_o[31:16] == 16'h0)
        else $error("mode register upper half not zero");
    for (genvar k = 0; k < 7; k++) begin : g_cmd
        if (k != 5) begin : g_bit
            a_cmd_irq: assert property (s_cmd_take(k) |-> ##3 irq_o)
                else $error("command did not raise the interrupt");
        end
    end
endmodule : tseg_event_gen_chk
bind tseg_event_gen tseg_event_gen_chk tseg_event_gen_chk_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .irq_o(irq_o));
`default_nettype wire

// ---- tseg_event_gen_tb.sv ----
// testbench: software commands, flags, capture and interrupts over the bus
`timescale 1ns/1ps
`default_nettype none
module tseg_event_gen_tb;
    logic        clk_i;         // 50 MHz clock
    logic        rst_b_i;       // reset, active low
    logic [7:0]  address_i;     // bus address
    logic        read_i;        // bus read
    logic        write_i;       // bus write
    logic [31:0] writedata_i;   // bus write data
    logic [3:0]  byteenable_i;  // byte enables
    logic [31:0] readdata_o;    // bus read data
    logic        waitrequest_o; // bus wait
    logic        irq_o;         // interrupt
    int          fail_count;    // mismatches
    int          checked;       // comparisons
    tseg_event_gen tseg_event_gen_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .irq_o(irq_o));
    // clock generator
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // counts, verdict and stop
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // compare one value
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        read_i      <= !wr;
        write_i     <= wr;
        address_i   <= a;
        writedata_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 50);
        q = readdata_o;
        read_i  <= 1'b0;
        write_i <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            $display("BAD waitrequest expected 0 seen %b", waitrequest_o);
            end_sim();
        end
    endtask : bus
    // register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    // register read and compare
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask : rd
    // interrupt level once the event has passed through status
    task automatic irq_chk(input logic e);
        repeat (3) @(posedge clk_i);
        #1;
        chk("irq_o", {31'h0, e}, {31'h0, irq_o});
    endtask : irq_chk
    // reset values and an unmapped place
    task automatic s_reset_vals;
        rd("flags", tseg_pkg::OFF_FLAGS, 32'h0);
        rd("evgen", tseg_pkg::OFF_EVGEN, 32'h0);
        rd("mode_a", tseg_pkg::OFF_CMODE_A, 32'h0);
        rd("unmapped", 8'h60, 32'h0);
        irq_chk(1'b0);
    endtask : s_reset_vals
    // trigger command: flag, interrupt, self-clear, read-clear of status
    task automatic s_trigger;
        wr(tseg_pkg::OFF_CMODE_A, 32'hffff_f800);
        rd("mode_a", tseg_pkg::OFF_CMODE_A, 32'h0000_f800);
        wr(tseg_pkg::OFF_EVGEN, 32'h0000_0040);
        irq_chk(1'b1);
        rd("flags", tseg_pkg::OFF_FLAGS, 32'h40);
        rd("evgen", tseg_pkg::OFF_EVGEN, 32'h0);
        rd("stat", tseg_pkg::OFF_IRQ_STAT, 32'h40);
        irq_chk(1'b0);
        wr(tseg_pkg::OFF_FLAGS, 32'h0);
        rd("flags", tseg_pkg::OFF_FLAGS, 32'h0);
    endtask : s_trigger
    // all channel commands at once in compare mode, then a zero write
    task automatic s_chan_cmp;
        wr(tseg_pkg::OFF_EVGEN, 32'h0000_001e);
        rd("flags", tseg_pkg::OFF_FLAGS, 32'h1e);
        wr(tseg_pkg::OFF_EVGEN, 32'h0000_0000);
        wr(tseg_pkg::OFF_EVGEN, 32'h0000_001e);
        rd("flags", tseg_pkg::OFF_FLAGS, 32'h1e);
        rd("stat", tseg_pkg::OFF_IRQ_STAT, 32'h1e);
        wr(tseg_pkg::OFF_FLAGS, 32'h0);
    endtask : s_chan_cmp
    // update command down, then forced capture and over-capture, then update command up
    task automatic s_update_cap;
        wr(tseg_pkg::OFF_RELOAD, 32'h0000_0abc);
        wr(tseg_pkg::OFF_CTRL, 32'h2);
        wr(tseg_pkg::OFF_EVGEN, 32'h1);
        rd("count", tseg_pkg::OFF_COUNT, 32'h0abc);
        rd("flags", tseg_pkg::OFF_FLAGS, 32'h1);
        wr(tseg_pkg::OFF_CCR1, 32'h0000_1234);
        wr(tseg_pkg::OFF_CMODE_A, 32'h1);
        wr(tseg_pkg::OFF_FLAGS, 32'h0);
        wr(tseg_pkg::OFF_EVGEN, 32'h2);
        rd("ccr1", tseg_pkg::OFF_CCR1, 32'h0abc);
        wr(tseg_pkg::OFF_EVGEN, 32'h2);
        rd("flags", tseg_pkg::OFF_FLAGS, 32'h202);
        wr(tseg_pkg::OFF_CTRL, 32'h0);
        wr(tseg_pkg::OFF_EVGEN, 32'h1);
        rd("count", tseg_pkg::OFF_COUNT, 32'h0);
        rd("stat", tseg_pkg::OFF_IRQ_STAT, 32'h3);
        byteenable_i <= 4'h1;
        wr(tseg_pkg::OFF_FLAGS, 32'h0);
        rd("flags", tseg_pkg::OFF_FLAGS, 32'h200);
        byteenable_i <= 4'hf;
        wr(tseg_pkg::OFF_FLAGS, 32'h0);
    endtask : s_update_cap
    // masked trigger keeps the interrupt low but sets status
    task automatic s_mask;
        wr(tseg_pkg::OFF_IRQ_MASK, 32'h40);
        wr(tseg_pkg::OFF_EVGEN, 32'h40);
        irq_chk(1'b0);
        rd("stat", tseg_pkg::OFF_IRQ_STAT, 32'h40);
    endtask : s_mask
    // main sequence
    initial begin
        {rst_b_i, read_i, write_i, address_i, writedata_i} = '0;
        byteenable_i = 4'hf;
        fail_count   = 0;
        checked      = 0;
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        s_reset_vals();
        s_trigger();
        s_chan_cmp();
        s_update_cap();
        s_mask();
        end_sim();
    end
endmodule : tseg_event_gen_tb
`default_nettype wire

// ---- tseg_pkg.sv ----
// package: register map, field positions and reset values of the event generator
package tseg_pkg;
    // byte offsets on the register bus
    localparam logic [7:0] OFF_CTRL     = 8'h00; // counter control
    localparam logic [7:0] OFF_FLAGS    = 8'h10; // timer_flags
    localparam logic [7:0] OFF_EVGEN    = 8'h14; // event_generation
    localparam logic [7:0] OFF_CMODE_A  = 8'h18; // channel_mode_a
    localparam logic [7:0] OFF_CMODE_B  = 8'h1c; // channel 3/4 mode
    localparam logic [7:0] OFF_COUNT    = 8'h24; // counter value
    localparam logic [7:0] OFF_PRESC    = 8'h28; // prescaler divide value
    localparam logic [7:0] OFF_RELOAD   = 8'h2c; // auto-reload value
    localparam logic [7:0] OFF_CCR1     = 8'h34; // chan1 capture/compare value
    localparam logic [7:0] OFF_IRQ_STAT = 8'h50; // sticky events, read clears
    localparam logic [7:0] OFF_IRQ_MASK = 8'h54; // interrupt mask
    localparam int         NUM_CHAN     = 4;     // capture/compare channels
    // event_generation and timer_flags low bit positions
    localparam int EV_UPDATE  = 0;  // update_event_gen / update_flag
    localparam int EV_CHAN1   = 1;  // chan1_event_gen / chan1_event_flag
    localparam int EV_TRIGGER = 6;  // trigger_event_gen / trigger_flag
    localparam int FL_OVCAP1  = 9;  // chan1_overcapture_flag
    localparam int EV_W       = 7;  // width of event field
    localparam int FL_W       = 13; // width of timer_flags
    localparam logic [EV_W-1:0] EV_MASK  = 7'h5f; // writable event bits
    localparam logic [FL_W-1:0] FL_MASK  = 13'h1e5f; // implemented flags
    // control register fields
    localparam int CTRL_RUN   = 0;  // counter enable
    localparam int CTRL_DOWN  = 1;  // count down when not center-aligned
    localparam int CTRL_CMS_L = 2;  // center-aligned mode, low bit
    localparam int CTRL_CMS_H = 3;  // center-aligned mode, high bit
    localparam int CTRL_W     = 4;  // control width
    // channel mode layout: selection per channel, output-compare fields
    localparam int CM_SEL_LO  = 0;  // first channel selection field
    localparam int CM_SEL_HI  = 8;  // second channel selection field
    localparam int CM_B_PE    = 11; // out_cmp_b_preload_en
    localparam int CM_B_MODE  = 12; // out_cmp_b_mode, 3 bits
    localparam int CM_B_CE    = 15; // out_cmp_b_clear_en
    localparam int CM_W       = 16; // implemented width
    localparam logic [15:0] RST_16 = 16'h0000; // reset of 16-bit registers
endpackage : tseg_pkg
